// ### hw/dbp_pwm_channel.sv
// Double-buffered PWM channel with its period timer, register port and
// interrupt. Assumes a single-master register port with one-cycle strobes
// and the output pin resolved from pinOut and pinOe by the surroundings.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module dbp_pwm_channel #(
    parameter logic [3:0] PWM_MODE_CODE = dbp_pkg::MODE_PWM_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] timerCount_reg; // Period timer count
    logic [7:0] periodLimit_reg; // Period limit
    logic [6:0] timerCtl_reg; // Postscale, run, prescale
    logic [7:0] dutyPending_reg; // Pending duty, high eight bits
    logic [7:0] dutyActive_reg; // Active duty, high eight bits
    logic [1:0] dutyLatch_reg; // Active duty, low two bits
    logic [5:0] chanCtl_reg; // Duty low bits and mode
    logic [1:0] irqStatus_reg; // Sticky event bits
    logic [1:0] irqMask_reg; // Interrupt enables
    logic [3:0] postCount_reg; // Postscale counter
    logic direction_reg; // Pin direction, one means input
    logic portLatch_reg; // General-purpose port data latch
    logic outLatch_reg; // Channel output latch
    logic pinInSync_reg; // Pin level, sampled for reads
    logic [7:0] regRdData_reg; // Read data register
    logic irq_reg; // Interrupt output register
    logic pinOut_reg; // Pin drive register
    logic pinOe_reg; // Pin enable register
    dbp_pkg::dbp_phase_t phase_reg; // Waveform phase
    dbp_pkg::dbp_phase_t phase_next; // Next waveform phase

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    logic tick; // One timer step
    logic [1:0] fineBits; // Two fine bits below the timer
    logic pwmMode; // Channel is in PWM mode
    logic match; // Timer equals period limit
    logic rollover; // Step that starts a new period
    logic [9:0] activeDuty; // Buffered ten-bit duty
    logic dutyHit; // Extended timer reached duty
    logic periodEvent; // Postscaled period interrupt event
    logic wrChanCtl; // Write to channel control
    logic [1:0] irqSet; // Events this cycle

    // Writes to an address
    function automatic logic wrAt(input logic [3:0] ofs);
        return regWrStb && (regAddr == ofs);
    endfunction

    // Prescaler and quarter-cycle bits
    dbp_prescaler uPre (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(timerCtl_reg[dbp_pkg::TCTL_RUN_BIT]),
        .preSel(timerCtl_reg[dbp_pkg::TCTL_PRESCALE_LSB +: 2]),
        .tick(tick),
        .fineBits(fineBits)
    );

    assign pwmMode = chanCtl_reg[dbp_pkg::CCTL_MODE_LSB +: 4]
        == PWM_MODE_CODE;
    assign match = timerCount_reg == periodLimit_reg;
    assign rollover = tick && match;
    assign activeDuty = {dutyActive_reg, dutyLatch_reg};
    // Compare duty with the timer extended by two fine bits
    assign dutyHit = activeDuty == {timerCount_reg, fineBits};
    assign wrChanCtl = wrAt(dbp_pkg::OFS_CHANNEL_CONTROL);

    // ------------------------------------------------------------
    // Period timer
    // ------------------------------------------------------------
    // Counts steps, clears on the step after the limit match
    // Each PWM channel instance steps its own copy of this timer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            timerCount_reg <= dbp_pkg::RST_BYTE;
        end else if (wrAt(dbp_pkg::OFS_TIMER_COUNT)) begin
            timerCount_reg <= regWrData;
        end else if (rollover) begin
            timerCount_reg <= dbp_pkg::RST_BYTE;
        end else if (tick) begin
            timerCount_reg <= timerCount_reg + 8'h01;
        end
    end

    // Period limit and timer control
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            periodLimit_reg <= dbp_pkg::RST_PERIOD_LIMIT;
            timerCtl_reg <= dbp_pkg::RST_BYTE[6:0];
        end else begin
            if (wrAt(dbp_pkg::OFS_PERIOD_LIMIT)) begin
                periodLimit_reg <= regWrData;
            end
            if (wrAt(dbp_pkg::OFS_TIMER_CONTROL)) begin
                timerCtl_reg <= regWrData[6:0];
            end
        end
    end

    // Postscaler divides only the interrupt, not the period
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            postCount_reg <= 4'h0;
        end else if (rollover) begin
            if (postCount_reg
                == timerCtl_reg[dbp_pkg::TCTL_POSTSCALE_LSB +: 4]) begin
                postCount_reg <= 4'h0;
            end else begin
                postCount_reg <= postCount_reg + 4'h1;
            end
        end
    end

    // Interrupt event on the last rollover of each postscale group
    assign periodEvent = rollover && (postCount_reg
        == timerCtl_reg[dbp_pkg::TCTL_POSTSCALE_LSB +: 4]);

    // ------------------------------------------------------------
    // Duty registers
    // ------------------------------------------------------------
    // Pending duty and channel control take writes at any time
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dutyPending_reg <= dbp_pkg::RST_BYTE;
            chanCtl_reg <= dbp_pkg::RST_BYTE[5:0];
        end else begin
            if (wrAt(dbp_pkg::OFS_DUTY_PENDING)) begin
                dutyPending_reg <= regWrData;
            end
            if (wrChanCtl) begin
                chanCtl_reg <= regWrData[5:0];
            end
        end
    end

    // High byte and low bits load together, so no period sees half a duty
    // Active duty loads at rollover or, outside PWM mode, on a write; writes ignored in PWM mode
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dutyActive_reg <= dbp_pkg::RST_BYTE;
            dutyLatch_reg <= 2'h0;
        end else if (rollover) begin
            dutyActive_reg <= dutyPending_reg;
            dutyLatch_reg <= chanCtl_reg[dbp_pkg::CCTL_DUTY_LOW_LSB +: 2];
        end else if (wrAt(dbp_pkg::OFS_DUTY_ACTIVE) && !pwmMode) begin
            dutyActive_reg <= regWrData;
        end
    end

    // ------------------------------------------------------------
    // Waveform
    // ------------------------------------------------------------
    // Next phase from rollover, duty hit and mode
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            dbp_pkg::DBP_IDLE: begin
                if (pwmMode && rollover) begin
                    phase_next = dbp_pkg::DBP_HIGH;
                end
            end
            dbp_pkg::DBP_HIGH: begin
                if (!pwmMode) begin
                    phase_next = dbp_pkg::DBP_IDLE;
                end else if (dutyHit && !rollover) begin
                    phase_next = dbp_pkg::DBP_LOW;
                end
            end
            dbp_pkg::DBP_LOW: begin
                if (!pwmMode) begin
                    phase_next = dbp_pkg::DBP_IDLE;
                end else if (rollover) begin
                    phase_next = dbp_pkg::DBP_HIGH;
                end
            end
            default: begin
                phase_next = dbp_pkg::DBP_IDLE;
            end
        endcase
    end

    // Phase register, idle after reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phase_reg <= dbp_pkg::DBP_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Output latch: set at rollover unless the new duty is zero
    // cleared on duty hit a duty past the period never hits
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            outLatch_reg <= 1'b0;
        end else if (wrChanCtl && regWrData == dbp_pkg::RST_BYTE) begin
            outLatch_reg <= 1'b0;
        end else if (!pwmMode) begin
            outLatch_reg <= outLatch_reg;
        end else if (rollover) begin
            outLatch_reg <= ({dutyPending_reg,
                chanCtl_reg[dbp_pkg::CCTL_DUTY_LOW_LSB +: 2]} != 10'h000);
        end else if (phase_reg == dbp_pkg::DBP_HIGH && dutyHit) begin
            outLatch_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin and port latch
    // ------------------------------------------------------------
    // Port data latch is separate and unaffected by control clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            direction_reg <= dbp_pkg::RST_DIRECTION;
            portLatch_reg <= 1'b0;
        end else begin
            if (wrAt(dbp_pkg::OFS_PIN_DIRECTION)) begin
                direction_reg <= regWrData[0];
            end
            if (wrAt(dbp_pkg::OFS_PORT_LATCH)) begin
                portLatch_reg <= regWrData[0];
            end
        end
    end

    // Pin drives only when software clears direction
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pinOut_reg <= 1'b0;
            pinOe_reg <= 1'b0;
            pinInSync_reg <= 1'b0;
        end else begin
            // Pin falls in the cycle the duty is reached
            if (pwmMode) begin
                pinOut_reg <= outLatch_reg
                    && !(phase_reg == dbp_pkg::DBP_HIGH && dutyHit);
            end else begin
                pinOut_reg <= portLatch_reg;
            end
            pinOe_reg <= !direction_reg;
            pinInSync_reg <= pinIn;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Every rollover and every postscaled period raise a status bit
    assign irqSet = {rollover, periodEvent};

    // Sticky bits, write one to clear, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqStatus_reg <= 2'h0;
            irqMask_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            if (wrAt(dbp_pkg::OFS_IRQ_STATUS)) begin
                irqStatus_reg <= (irqStatus_reg & ~regWrData[1:0]) | irqSet;
            end else begin
                irqStatus_reg <= irqStatus_reg | irqSet;
            end
            if (wrAt(dbp_pkg::OFS_IRQ_MASK)) begin
                irqMask_reg <= regWrData[1:0];
            end
            irq_reg <= |((irqStatus_reg | irqSet) & irqMask_reg);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Read data one cycle after the strobe, zero otherwise
    // Spare and unmapped bits read as zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !regRdStb) begin
            regRdData_reg <= 8'h00;
        end else if (regAddr == dbp_pkg::OFS_TIMER_COUNT) begin
            regRdData_reg <= timerCount_reg;
        end else if (regAddr == dbp_pkg::OFS_PERIOD_LIMIT) begin
            regRdData_reg <= periodLimit_reg;
        end else if (regAddr == dbp_pkg::OFS_TIMER_CONTROL) begin
            regRdData_reg <= {1'b0, timerCtl_reg};
        end else if (regAddr == dbp_pkg::OFS_DUTY_PENDING) begin
            regRdData_reg <= dutyPending_reg;
        end else if (regAddr == dbp_pkg::OFS_DUTY_ACTIVE) begin
            regRdData_reg <= dutyActive_reg;
        end else if (regAddr == dbp_pkg::OFS_CHANNEL_CONTROL) begin
            regRdData_reg <= {2'h0, chanCtl_reg};
        end else if (regAddr == dbp_pkg::OFS_IRQ_STATUS) begin
            regRdData_reg <= {6'h00, irqStatus_reg};
        end else if (regAddr == dbp_pkg::OFS_IRQ_MASK) begin
            regRdData_reg <= {6'h00, irqMask_reg};
        end else if (regAddr == dbp_pkg::OFS_PIN_DIRECTION) begin
            regRdData_reg <= {7'h00, direction_reg};
        end else if (regAddr == dbp_pkg::OFS_PORT_LATCH) begin
            regRdData_reg <= {6'h00, pinInSync_reg, portLatch_reg};
        end else begin
            regRdData_reg <= 8'h00;
        end
    end

    // Outputs come straight from their registers
    assign regRdData = regRdData_reg;
    assign pinOut = pinOut_reg;
    assign pinOe = pinOe_reg;
    assign irq = irq_reg;
endmodule

// ### hw/dbp_pkg.sv
// Package: register map, field positions, reset values and timing counts
// for the double-buffered PWM channel.
// Assumes a plain register port with 8-bit data and a 25 MHz system clock.
package dbp_pkg;

    // ------------------------------------------------------------
    // Register offsets (plain port, one byte per address)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_TIMER_COUNT = 4'h0;
    localparam logic [3:0] OFS_PERIOD_LIMIT = 4'h1;
    localparam logic [3:0] OFS_TIMER_CONTROL = 4'h2;
    localparam logic [3:0] OFS_DUTY_PENDING = 4'h3;
    localparam logic [3:0] OFS_DUTY_ACTIVE = 4'h4;
    localparam logic [3:0] OFS_CHANNEL_CONTROL = 4'h5;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h7;
    localparam logic [3:0] OFS_PIN_DIRECTION = 4'h8;
    localparam logic [3:0] OFS_PORT_LATCH = 4'h9;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TCTL_PRESCALE_LSB = 0;
    localparam int TCTL_RUN_BIT = 2;
    localparam int TCTL_POSTSCALE_LSB = 3;
    localparam int CCTL_MODE_LSB = 0;
    localparam int CCTL_DUTY_LOW_LSB = 4;
    localparam int IRQ_PERIOD_BIT = 0;
    localparam int IRQ_ROLLOVER_BIT = 1;

    // ------------------------------------------------------------
    // Masks of implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TCTL_MASK = 8'h7f;
    localparam logic [7:0] CCTL_MASK = 8'h3f;
    localparam logic [7:0] IRQ_MASK_BITS = 8'h03;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT = 8'hff;
    localparam logic RST_DIRECTION = 1'b1;

    // ------------------------------------------------------------
    // Modes and prescale selections
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_PWM_DEFAULT = 4'hc;
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;

    // ------------------------------------------------------------
    // Timing: one instruction cycle is four oscillator periods
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int OSC_PER_TICK = 4;
    localparam int QCLK_COUNT = OSC_PER_TICK;

    typedef enum logic [1:0] {
        DBP_IDLE = 2'b00,
        DBP_HIGH = 2'b01,
        DBP_LOW = 2'b11
    } dbp_phase_t;

endpackage

// ### hw/dbp_prescaler.sv
// Period timer prescaler and quarter-cycle counter.
// Assumes sys_clk acts as the oscillator; one tick per four clocks at 1:1 prescale.
`timescale 1ns/1ps
module dbp_prescaler (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [1:0] preSel,
    output logic tick,
    output logic [1:0] fineBits
);
    // ------------------------------------------------------------
    // Fine counter: two quarter bits and up to four prescale bits
    // ------------------------------------------------------------
    logic [5:0] fine_reg; // Oscillator periods within one timer step
    logic [5:0] lastVal; // Last fine count for this prescale ratio

    // Last count before a timer increment, for ratios 1, 4 and 16
    always_comb begin
        if (preSel == dbp_pkg::PRE_DIV1) begin
            lastVal = 6'h03;
        end else if (preSel == dbp_pkg::PRE_DIV4) begin
            lastVal = 6'h0f;
        end else begin
            lastVal = 6'h3f;
        end
    end

    // Counts oscillator periods while the timer runs
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !run) begin
            fine_reg <= 6'h00;
        end else if (fine_reg >= lastVal) begin
            fine_reg <= 6'h00;
        end else begin
            fine_reg <= fine_reg + 6'h01;
        end
    end

    // One-cycle step pulse at the end of each prescaled period
    assign tick = run && (fine_reg >= lastVal);

    // Two fine bits: quarter clock at 1:1, top prescale bits otherwise
    always_comb begin
        if (preSel == dbp_pkg::PRE_DIV1) begin
            fineBits = fine_reg[1:0];
        end else if (preSel == dbp_pkg::PRE_DIV4) begin
            fineBits = fine_reg[3:2];
        end else begin
            fineBits = fine_reg[5:4];
        end
    end
endmodule

// ### tb/dbp_pwm_channel_sva.sv
// Checker for the PWM channel register port and pin.
// Assumes it is bound to dbp_pwm_channel and sees only its ports.
`timescale 1ns/1ps
module dbp_pwm_channel_sva (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic pinIn,
    input wire logic pinOut,
    input wire logic pinOe,
    input wire logic irq
);
    // ----------------------------------------
    // Shadow of the port latch bit
    // ----------------------------------------
    logic portSh_reg; // Last port latch value written
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portSh_reg <= 1'b0;
        end else if (regWrStb && regAddr == dbp_pkg::OFS_PORT_LATCH) begin
            portSh_reg <= regWrData[0];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    chk_rd_idle: assert property (
        !regRdStb |=> regRdData == 8'h00)
        else $error("read data not zero outside a read");
    chk_rd_unmapped: assert property (
        (regRdStb && regAddr > dbp_pkg::OFS_PORT_LATCH)
        |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    chk_duty_spare: assert property (
        (regRdStb && regAddr == dbp_pkg::OFS_CHANNEL_CONTROL)
        |=> regRdData[7:6] == 2'b00)
        else $error("control spare bits not zero");
    chk_tctl_spare: assert property (
        (regRdStb && regAddr == dbp_pkg::OFS_TIMER_CONTROL)
        |=> !regRdData[7])
        else $error("timer control spare bit not zero");
    chk_pend_back: assert property (
        (regWrStb && regAddr == dbp_pkg::OFS_DUTY_PENDING) ##1
        !(regWrStb && regAddr == dbp_pkg::OFS_DUTY_PENDING) ##1
        (regRdStb && regAddr == dbp_pkg::OFS_DUTY_PENDING)
        |=> regRdData == $past(regWrData, 3))
        else $error("pending duty not read back");
    chk_dir_oe: assert property (
        (regWrStb && regAddr == dbp_pkg::OFS_PIN_DIRECTION
        && !regWrData[0]) |-> ##3 pinOe)
        else $error("pin not driven after direction cleared");
    chk_irq_masked: assert property (
        (regWrStb && regAddr == dbp_pkg::OFS_IRQ_MASK
        && regWrData[1:0] == 2'b00) |-> ##3 !irq)
        else $error("interrupt high with all events masked");
    chk_clear_latch: assert property (
        (regWrStb && regAddr == dbp_pkg::OFS_CHANNEL_CONTROL
        && regWrData == 8'h00) |-> ##3 pinOut == portSh_reg)
        else $error("pin not back on port latch after clear");
endmodule
bind dbp_pwm_channel dbp_pwm_channel_sva chk_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .irq(irq)
);

// ### tb/dbp_load_model.sv
// Load on the PWM pin: resolves its level and measures pulses.
// Assumes a pull-down on the pin and sampling on the system clock.
`timescale 1ns/1ps
module dbp_load_model (
    input wire logic sys_clk,
    input wire logic pinOut,
    input wire logic pinOe,
    output logic pinLevel,
    output logic [15:0] highLen,
    output logic [15:0] perLen
);
    logic prev_reg = 1'b0; // Pin level one clock ago
    logic [15:0] cnt_reg = 16'h0000; // Clocks since last rise
    // Pull-down holds the pin low while nobody drives it
    assign pinLevel = pinOe ? pinOut : 1'b0;
    // Period at each rise, high time at each fall
    always_ff @(posedge sys_clk) begin
        prev_reg <= pinLevel;
        if (pinLevel && !prev_reg) begin
            perLen <= cnt_reg;
            cnt_reg <= 16'h0001;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
        if (!pinLevel && prev_reg) begin
            highLen <= cnt_reg;
        end
    end
endmodule

// ### tb/tb_top.sv
// Testbench: drives the channel registers and judges the pin.
// Assumes the default mode code and the pull-down load model.
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // Short addresses and mode code
    // ----------------------------------------
    localparam logic [3:0] A_TCTL = dbp_pkg::OFS_TIMER_CONTROL;
    localparam logic [3:0] A_PEND = dbp_pkg::OFS_DUTY_PENDING;
    localparam logic [3:0] A_ACT = dbp_pkg::OFS_DUTY_ACTIVE;
    localparam logic [3:0] A_CCTL = dbp_pkg::OFS_CHANNEL_CONTROL;
    localparam logic [3:0] A_STAT = dbp_pkg::OFS_IRQ_STATUS;
    localparam logic [3:0] A_MASK = dbp_pkg::OFS_IRQ_MASK;
    localparam logic [3:0] A_LAT = dbp_pkg::OFS_PORT_LATCH;
    localparam logic [7:0] MODE = {4'h0, dbp_pkg::MODE_PWM_DEFAULT};
    logic sys_clk;
    logic sys_rst;
    logic [3:0] regAddr;
    logic [7:0] regWrData;
    logic regWrStb;
    logic regRdStb;
    logic [7:0] regRdData;
    logic pinOut;
    logic pinOe;
    logic irq;
    logic pinLevel; // Resolved pin level
    logic [15:0] highLen; // Last high time in clocks
    logic [15:0] perLen; // Last period in clocks
    int err_count;
    int cmp_count;
    dbp_pwm_channel uut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .pinIn(pinLevel),
        .pinOut(pinOut), .pinOe(pinOe), .irq(irq)
    );
    dbp_load_model loadModel (
        .sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe),
        .pinLevel(pinLevel), .highLen(highLen), .perLen(perLen)
    );
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        @(posedge sys_clk);
        cmp({8'h00, regRdData}, {8'h00, exp});
    endtask
    // Wait for a rising pin edge, bounded, then let the load update
    task automatic wait_rise();
        int n;
        n = 0;
        while (pinLevel !== 1'b0 && n < 4000) begin
            @(posedge sys_clk);
            n++;
        end
        while (pinLevel !== 1'b1 && n < 4000) begin
            @(posedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        cmp(16'(n / 4000), 16'h0000);
    endtask
    // Count clocks on which the pin leaves the given level
    task automatic watch(input logic lvl);
        int n;
        n = 0;
        repeat (48) begin
            @(posedge sys_clk);
            if (pinLevel !== lvl) n++;
        end
        cmp(16'(n), 16'h0000);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] rv [10];
        rv = '{8'h00, dbp_pkg::RST_PERIOD_LIMIT, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, {7'h00, dbp_pkg::RST_DIRECTION}, 8'h00};
        for (int i = 0; i < 10; i++) begin
            rdc(4'(i), rv[i]);
        end
        cmp({15'h0000, pinOe}, 16'h0000);
        wr(4'hf, 8'hff);
        rdc(4'hf, 8'h00);
    endtask
    // Setup order, then every prescale ratio: period and high time
    task automatic t_pwm();
        wr(dbp_pkg::OFS_PERIOD_LIMIT, 8'h03);
        wr(A_PEND, 8'h02);
        wr(A_CCTL, 8'h30);
        wr(dbp_pkg::OFS_PIN_DIRECTION, 8'h00);
        for (int i = 2; i >= 0; i--) begin
            wr(A_TCTL, 8'h04 | 8'(i));
            if (i == 2) wr(A_CCTL, 8'h30 | MODE);
            wait_rise();
            wait_rise();
            cmp(perLen, 16'(16 << (2 * i)));
            cmp(highLen, 16'(11 << (2 * i)));
        end
    endtask
    // New duty written mid-pulse must wait for the rollover
    task automatic t_buffer();
        wait_rise();
        wr(A_PEND, 8'h01);
        rdc(A_PEND, 8'h01);
        wr(A_CCTL, MODE);
        wait_rise();
        cmp(highLen, 16'd11);
        wait_rise();
        cmp(highLen, 16'd4);
        rdc(A_ACT, 8'h01);
        wr(A_ACT, 8'hff);
        rdc(A_ACT, 8'h01);
    endtask
    task automatic t_edges();
        wr(A_PEND, 8'h00);
        repeat (40) @(posedge sys_clk);
        watch(1'b0);
        wr(A_PEND, 8'hff);
        wr(A_CCTL, 8'h30 | MODE);
        repeat (40) @(posedge sys_clk);
        watch(1'b1);
    endtask
    // Postscaler leaves the period alone; status, mask and clear
    task automatic t_irq();
        wr(A_TCTL, 8'h0c);
        wr(A_PEND, 8'h02);
        wait_rise();
        wait_rise();
        cmp(perLen, 16'd16);
        rdc(A_STAT, 8'h03);
        wr(A_MASK, 8'h02);
        repeat (2) @(posedge sys_clk);
        cmp({15'h0000, irq}, 16'h0001);
        wr(A_MASK, 8'h00);
        repeat (3) @(posedge sys_clk);
        cmp({15'h0000, irq}, 16'h0000);
        wr(A_TCTL, 8'h00);
        wr(A_STAT, 8'h03);
        rdc(A_STAT, 8'h00);
        wr(A_MASK, 8'h03);
        repeat (3) @(posedge sys_clk);
        cmp({15'h0000, irq}, 16'h0000);
    endtask
    // Clearing control hands the pin back to the untouched port latch
    task automatic t_clear();
        wr(A_LAT, 8'h01);
        wr(A_CCTL, 8'h00);
        repeat (4) @(posedge sys_clk);
        cmp({15'h0000, pinLevel}, 16'h0001);
        rdc(A_LAT, 8'h03);
        wr(A_LAT, 8'h00);
        repeat (4) @(posedge sys_clk);
        cmp({15'h0000, pinLevel}, 16'h0000);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, main sequence and watchdog
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        sys_rst = 1'b1;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        err_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_pwm();
        t_buffer();
        t_edges();
        t_irq();
        t_clear();
        complete_run();
    end
    // Whole run needs about a thousand clocks; allow far more
    initial begin
        #(40 * 20000);
        err_count++;
        complete_run();
    end
endmodule
